// >>> core/pes_pkg.sv
// Constants for the port E and pin steering block
// Behaviour
// - Up to 35 general purpose pins overall
// - Enabled peripheral takes pin from GPIO
// - Steering register routes functions between two pins
// - Bit 1 picks slave-select pin, reset 0
// - Bit 0 picks compare/PWM two pin
// - Four-bit port, direction bit per pin
// - Direction 1 makes pin input, driver off
// - Direction 0 drives pin from latch
// - Bit 3 input only, direction reads 1
// - Data read gives pins, write sets latch
// - Writes are read-modify-write of port; here a write loads pwdata[3:0] straight into the latch
// - Input-only pin reads 0 with master clear
// - Direction still drives analog-selected pins
// - Analog-selected pins read 0 digitally
package pes_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] PES_OFF_DATA = 12'h000;
    localparam logic [11:0] PES_OFF_DIR = 12'h004;
    localparam logic [11:0] PES_OFF_ANSEL = 12'h008;
    localparam logic [11:0] PES_OFF_STEER = 12'h00C;
    localparam logic [11:0] PES_OFF_CFG = 12'h010;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int PES_WIDTH = 4;
    localparam int PES_IN_ONLY_BIT = 3;
    localparam int PES_SS_SEL_BIT = 1;
    localparam int PES_CCP_SEL_BIT = 0;
    localparam int PES_MCLR_BIT = 0;
    localparam int PES_GPIO_TOTAL = 35;
    localparam logic [3:0] PES_DIR_RESET = 4'hF;
    localparam logic [3:0] PES_ANSEL_RESET = 4'h7;
    localparam logic [3:0] PES_LATCH_RESET = 4'h0;
    localparam logic [7:0] PES_STEER_RESET = 8'h00;
    localparam logic [1:0] PES_STEER_MASK = 2'h3;
endpackage : pes_pkg

// >>> core/pes_steer.sv
// Two-way pin steering for one peripheral function
`timescale 1ns/1ps
`default_nettype none
module pes_steer (
    input wire logic sel,
    input wire logic fn_oe,
    input wire logic fn_out,
    output logic prim_own,
    output logic alt_own,
    output logic prim_oe,
    output logic alt_oe,
    output logic prim_out,
    output logic alt_out
);
    import pes_pkg::*;
    // The unselected pin gets fn_out but no output enable, so it falls back to GPIO
    assign prim_own = !sel;
    assign alt_own = sel;
    assign prim_oe = !sel && fn_oe;
    assign alt_oe = sel && fn_oe;
    assign prim_out = fn_out;
    assign alt_out = fn_out;
endmodule : pes_steer
`default_nettype wire

// >>> core/pes_apb.sv
// APB slave decode for the port E register file
`timescale 1ns/1ps
`default_nettype none
module pes_apb (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    output logic wr_data,
    output logic wr_dir,
    output logic wr_ansel,
    output logic wr_steer,
    output logic wr_cfg,
    output logic rd_go,
    output logic bad_addr
);
    import pes_pkg::*;
    logic acc;
    assign acc = psel && penable;
    assign wr_data = acc && pwrite && paddr == PES_OFF_DATA;
    assign wr_dir = acc && pwrite && paddr == PES_OFF_DIR;
    assign wr_ansel = acc && pwrite && paddr == PES_OFF_ANSEL;
    assign wr_steer = acc && pwrite && paddr == PES_OFF_STEER;
    assign wr_cfg = acc && pwrite && paddr == PES_OFF_CFG;
    assign rd_go = psel && !penable && !pwrite;
    assign bad_addr = !(paddr == PES_OFF_DATA || paddr == PES_OFF_DIR
        || paddr == PES_OFF_ANSEL || paddr == PES_OFF_STEER || paddr == PES_OFF_CFG);
endmodule : pes_apb
`default_nettype wire

// >>> core/pes_top.sv
// Port E GPIO with pin steering, APB register file
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pes_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pes_pkg::PES_WIDTH-1:0] port_e_in,
    output logic [pes_pkg::PES_WIDTH-1:0] port_e_out,
    output logic [pes_pkg::PES_WIDTH-1:0] port_e_oe,
    input wire logic port_a_bit5_in,
    input wire logic port_a_bit0_in,
    output logic slave_select_n,
    input wire logic capture_pwm_unit_two_oe,
    input wire logic capture_pwm_unit_two_out,
    output logic port_c_bit1_oe,
    output logic port_c_bit1_out,
    output logic port_b_bit3_oe,
    output logic port_b_bit3_out,
    output logic port_c_bit1_gpio,
    output logic port_b_bit3_gpio,
    output logic port_a_bit5_gpio,
    output logic port_a_bit0_gpio
);
    import pes_pkg::*;
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [3:0] latch_q;
    logic [3:0] dir_q;
    logic [3:0] ansel_q;
    logic [7:0] steer_q;
    logic mclr_q;
    logic wr_data, wr_dir, wr_ansel, wr_steer, wr_cfg, rd_go, bad_addr;
    logic [3:0] pin_view;
    logic [3:0] dir_view;
    logic [31:0] rdata_d;
    logic c_prim_own, c_alt_own, c_prim_oe, c_alt_oe, c_prim_out, c_alt_out;

    pes_apb u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .wr_data(wr_data),
        .wr_dir(wr_dir),
        .wr_ansel(wr_ansel),
        .wr_steer(wr_steer),
        .wr_cfg(wr_cfg),
        .rd_go(rd_go),
        .bad_addr(bad_addr)
    );

    // ------------------------------------------------------------
    // Pin view: analog and master-clear masking
    // ------------------------------------------------------------
    always_comb begin
        pin_view = port_e_in & ~ansel_q;
        if (mclr_q) begin
            pin_view[PES_IN_ONLY_BIT] = 1'b0;
        end
        dir_view = dir_q;
        dir_view[PES_IN_ONLY_BIT] = 1'b1;
    end

    // Write stores into latch; pins read back elsewhere, never latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= PES_LATCH_RESET;
        end else if (wr_data) begin
            latch_q <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= PES_DIR_RESET;
        end else if (wr_dir) begin
            dir_q <= pwdata[3:0] | 4'h8;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ansel_q <= PES_ANSEL_RESET;
        end else if (wr_ansel) begin
            ansel_q <= pwdata[3:0] & 4'h7;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_q <= PES_STEER_RESET;
        end else if (wr_steer) begin
            steer_q <= {6'h00, pwdata[1:0] & PES_STEER_MASK};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclr_q <= 1'b0;
        end else if (wr_cfg) begin
            mclr_q <= pwdata[PES_MCLR_BIT];
        end
    end

    // ------------------------------------------------------------
    // Port drivers: direction governs even analog pins
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_e_oe <= 4'h0;
            port_e_out <= 4'h0;
        end else begin
            port_e_oe <= ~dir_view;
            port_e_out <= latch_q & ~dir_view;
        end
    end

    // ------------------------------------------------------------
    // Steering
    // ------------------------------------------------------------
    pes_steer u_ccp (
        .sel(steer_q[PES_CCP_SEL_BIT]),
        .fn_oe(capture_pwm_unit_two_oe),
        .fn_out(capture_pwm_unit_two_out),
        .prim_own(c_prim_own),
        .alt_own(c_alt_own),
        .prim_oe(c_prim_oe),
        .alt_oe(c_alt_oe),
        .prim_out(c_prim_out),
        .alt_out(c_alt_out)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_select_n <= 1'b1;
            port_c_bit1_oe <= 1'b0;
            port_c_bit1_out <= 1'b0;
            port_b_bit3_oe <= 1'b0;
            port_b_bit3_out <= 1'b0;
            port_c_bit1_gpio <= 1'b1;
            port_b_bit3_gpio <= 1'b1;
            port_a_bit5_gpio <= 1'b1;
            port_a_bit0_gpio <= 1'b1;
        end else begin
            slave_select_n <= steer_q[PES_SS_SEL_BIT] ? port_a_bit0_in
                : port_a_bit5_in;
            port_c_bit1_oe <= c_prim_oe;
            port_c_bit1_out <= c_prim_out;
            port_b_bit3_oe <= c_alt_oe;
            port_b_bit3_out <= c_alt_out;
            // A pin whose function sits elsewhere stays plain GPIO
            port_c_bit1_gpio <= !(c_prim_own && capture_pwm_unit_two_oe);
            port_b_bit3_gpio <= !(c_alt_own && capture_pwm_unit_two_oe);
            port_a_bit5_gpio <= steer_q[PES_SS_SEL_BIT];
            port_a_bit0_gpio <= !steer_q[PES_SS_SEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // APB read and answer; single wait-free access phase
    // ------------------------------------------------------------
    always_comb begin
        case (paddr)
            PES_OFF_DATA: rdata_d = {28'h0, pin_view};
            PES_OFF_DIR: rdata_d = {28'h0, dir_view};
            PES_OFF_ANSEL: rdata_d = {28'h0, ansel_q};
            PES_OFF_STEER: rdata_d = {24'h0, steer_q};
            PES_OFF_CFG: rdata_d = {31'h0, mclr_q};
            default: rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (rd_go) begin
                prdata <= rdata_d;
            end
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad_addr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    in_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        !port_e_oe[PES_IN_ONLY_BIT]) else $error("input-only pin driven");
    dir_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> port_e_oe == ~$past(dir_view)) else $error("driver not per direction");
    latch_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data && !dir_q[0] |=> ##1 port_e_out[0] == $past(pwdata[0], 2))
        else $error("latch not driven");
    ss_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> slave_select_n == ($past(steer_q[1]) ? $past(port_a_bit0_in)
        : $past(port_a_bit5_in))) else $error("slave select misrouted");
    ccp_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(port_c_bit1_oe && port_b_bit3_oe)) else $error("both ccp pins driven");
    steer_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
        steer_q[7:2] == 6'h00) else $error("steering reserved bits set");
    mclr_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        mclr_q |-> !pin_view[PES_IN_ONLY_BIT]) else $error("input-only pin not zero");
    analog_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_view & ansel_q) == 4'h0) else $error("analog pin read nonzero");
    ready_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready) else $error("no answer in access phase");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready held too long");
    err_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && bad_addr |=> pslverr) else $error("unmapped access not flagged");
    latch_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_data |=> $stable(latch_q)) else $error("latch changed without write");
    ss_free_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> port_a_bit5_gpio != port_a_bit0_gpio) else $error("slave select pin ownership");
    ccp_own_c_a: assert property (@(posedge pclk) disable iff (!presetn)
        port_c_bit1_oe |-> !port_c_bit1_gpio) else $error("driven pin still marked free");
    ccp_own_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        port_b_bit3_oe |-> !port_b_bit3_gpio) else $error("driven pin still marked free");
    ccp_vacate_a: assert property (@(posedge pclk) disable iff (!presetn)
        port_b_bit3_oe |-> port_c_bit1_gpio) else $error("vacated pin not released");
endmodule : pes_top
`default_nettype wire

// >>> sim/pes_pins.sv
// Board model of the port E pins
`timescale 1ns/1ps
`default_nettype none
module pes_pins (
    input wire logic [pes_pkg::PES_WIDTH-1:0] port_e_out,
    input wire logic [pes_pkg::PES_WIDTH-1:0] port_e_oe,
    input wire logic [pes_pkg::PES_WIDTH-1:0] ext_level,
    output logic [pes_pkg::PES_WIDTH-1:0] port_e_in
);
    import pes_pkg::*;
    // Released pins show the board level, which the bench keeps changing
    always_comb begin
        for (int i = 0; i < PES_WIDTH; i++) begin
            port_e_in[i] = port_e_oe[i] ? port_e_out[i] : ext_level[i];
        end
    end
endmodule : pes_pins
`default_nettype wire

// >>> sim/pes_top_tb_top.sv
// Self-checking bench for the port E block
`timescale 1ns/1ps
`default_nettype none
module pes_top_tb_top;
    import pes_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, t, lf = 32'hBD7B;
    logic pready, pslverr, ss_n, c1_oe, c1_out, b3_oe, b3_out, c1_g, b3_g, a5_g, a0_g;
    logic a5 = 0, a0 = 0, c_oe = 0, c_out = 0, mc;
    logic [3:0] port_e_in, port_e_out, port_e_oe, ext = 4'h0, dir, lat, ans, oe_x;
    logic [1:0] s;
    logic [33:0] q[$];
    logic [33:0] e;
    int n_fail = 0, n_checks = 0;
    // ------------------------------------------------------------
    // Design and board
    // ------------------------------------------------------------
    pes_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_e_in(port_e_in), .port_e_out(port_e_out),
        .port_e_oe(port_e_oe), .port_a_bit5_in(a5), .port_a_bit0_in(a0),
        .slave_select_n(ss_n), .capture_pwm_unit_two_oe(c_oe), .capture_pwm_unit_two_out(c_out), .port_c_bit1_oe(c1_oe),
        .port_c_bit1_out(c1_out), .port_b_bit3_oe(b3_oe), .port_b_bit3_out(b3_out),
        .port_c_bit1_gpio(c1_g), .port_b_bit3_gpio(b3_g), .port_a_bit5_gpio(a5_g),
        .port_a_bit0_gpio(a0_g));
    pes_pins i_pins (.port_e_out(port_e_out), .port_e_oe(port_e_oe), .ext_level(ext),
        .port_e_in(port_e_in));
    initial begin
        forever #2 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction : rnd
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // Request held until pready is seen; expectation queued for the monitor
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic err, input logic [31:0] rd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        q.push_back({w, err, rd});
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Pins read back, analog-selected ones and the input-only pin under master clear as 0
    task rd_data();
        logic [3:0] p;
        p = ext;
        for (int i = 0; i < 3; i++) if (!dir[i]) p[i] = lat[i];
        apb(1'b0, PES_OFF_DATA, 32'h0, 1'b0, {28'h0, p & ~{mc, ans[2:0]}});
    endtask : rd_data
    always @(posedge pclk) begin
        if (pready === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            check(pslverr, e[32]);
            if (!e[33]) check(prdata, e[31:0]);
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        check(port_e_oe, 4'h0);
        presetn <= 1'b1;
        dir = 4'hF;
        lat = 4'h0;
        ans = 4'h7;
        mc = 1'b0;
        apb(1'b0, PES_OFF_DIR, 32'h0, 1'b0, 32'hF);
        apb(1'b0, PES_OFF_ANSEL, 32'h0, 1'b0, 32'h7);
        apb(1'b0, PES_OFF_STEER, 32'h0, 1'b0, 32'h0);
        apb(1'b0, PES_OFF_CFG, 32'h0, 1'b0, 32'h0);
        rd_data();
        apb(1'b1, 12'h020, 32'h5, 1'b1, 32'h0);
        apb(1'b0, 12'h020, 32'h0, 1'b1, 32'h0);
        for (int n = 0; n < 8; n++) begin
            t = rnd();
            ext <= t[3:0];
            lat = t[11:8];
            ans = {1'b0, t[14:12]};
            // Odd rounds keep analog pins as inputs; even rounds leave some as outputs
            dir = (n == 0) ? 4'h0 : (n[0] ? (t[7:4] | ans) : t[7:4]);
            mc = t[15];
            // Analog pins left as outputs on purpose: drivers must still follow direction
            apb(1'b1, PES_OFF_ANSEL, {28'h0, ans}, 1'b0, 32'h0);
            apb(1'b1, PES_OFF_DIR, {28'h0, dir}, 1'b0, 32'h0);
            apb(1'b1, PES_OFF_DATA, {28'h0, lat}, 1'b0, 32'h0);
            apb(1'b1, PES_OFF_CFG, {31'h0, mc}, 1'b0, 32'h0);
            dir[3] = 1'b1;
            oe_x = {1'b0, ~dir[2:0]};
            repeat (3) @(posedge pclk);
            check(port_e_oe, oe_x);
            check(port_e_out & oe_x, lat & oe_x);
            apb(1'b0, PES_OFF_DIR, 32'h0, 1'b0, {28'h0, dir});
            rd_data();
            apb(1'b0, PES_OFF_ANSEL, 32'h0, 1'b0, {28'h0, ans});
            apb(1'b0, PES_OFF_CFG, 32'h0, 1'b0, {31'h0, mc});
        end
        for (int n = 0; n < 4; n++) begin
            s = n[1:0];
            t = rnd();
            a5 <= t[0];
            a0 <= t[1];
            c_oe <= t[2];
            c_out <= t[3];
            apb(1'b1, PES_OFF_STEER, {30'h3FFFFFFF, s}, 1'b0, 32'h0);
            repeat (3) @(posedge pclk);
            check(ss_n, s[1] ? t[1] : t[0]);
            check(s[0] ? b3_oe : c1_oe, t[2]);
            check(s[0] ? b3_out : c1_out, t[3]);
            check(s[1] ? a5_g : a0_g, 1'b1);
            check(s[0] ? c1_g : b3_g, 1'b1);
            check(s[0] ? c1_oe : b3_oe, 1'b0);
            check(s[0] ? b3_g : c1_g, !t[2]);
            check(s[1] ? a0_g : a5_g, 1'b0);
            apb(1'b0, PES_OFF_STEER, 32'h0, 1'b0, {30'h0, s});
        end
        summarize();
    end
endmodule : pes_top_tb_top
`default_nettype wire
